// [rtl/upoc_pkg.sv]
// Package for the serial port one control block: register map, field layout, types.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package upoc_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;  // serial_port_one_control
  localparam logic [7:0] AUX_OFS     = 8'h04;  // Alternate select, interrupt enable
  localparam logic [7:0] TXDATA_OFS  = 8'h08;  // Transmit byte, write starts a frame
  localparam logic [7:0] RXDATA_OFS  = 8'h0C;  // Last accepted receive byte
  localparam logic [7:0] ADDR_OFS    = 8'h10;  // Given address and broadcast address
  localparam logic [7:0] IRQST_OFS   = 8'h14;  // Sticky event status, write one to clear
  localparam logic [7:0] IRQMSK_OFS  = 8'h18;  // Event mask
  localparam logic [7:0] BAUD_OFS    = 8'h1C;  // Bit period divider

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int MODE_HI_BIT  = 7;
  localparam int MODE_LO_BIT  = 6;
  localparam int MPF_BIT      = 5;
  localparam int RXEN_BIT     = 4;
  localparam int TX9_BIT      = 3;
  localparam int RX9_BIT      = 2;
  localparam int TXDONE_BIT   = 1;
  localparam int RXDONE_BIT   = 0;
  localparam int ALTSEL_BIT   = 0;  // In AUX
  localparam int IEN_BIT      = 1;  // In AUX

  // Event status bits
  localparam int EV_TX = 0;
  localparam int EV_RX = 1;
  localparam int EV_FE = 2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  GIVEN_RST = 8'h00;
  localparam logic [7:0]  BCAST_RST = 8'hFF;
  localparam logic [15:0] BAUD_RST  = 16'h0363;  // 115200 baud at 100 MHz
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;

  // Serial modes
  typedef enum logic [1:0] {
    UPOC_M0 = 2'b00,
    UPOC_M1 = 2'b01,
    UPOC_M2 = 2'b10,
    UPOC_M3 = 2'b11
  } upoc_mode_t;

  // Frame from the shifter
  typedef struct packed {
    logic [7:0] data;
    logic       bit9;   // Ninth bit, or stop bit in mode 1
    logic       stop;   // Sampled stop bit level
  } upoc_rxfrm_t;

endpackage

// [rtl/upoc_shift.sv]
// Serial shifter for serial port one: one frame out and one frame in.
// Assumes a one-cycle bit enable from the parent; line input already synchronous.
`timescale 1ns/1ps
module upoc_shift (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Timing and mode
  input  wire logic                  bit_en,
  input  wire upoc_pkg::upoc_mode_t  mode,
  // Transmit side
  input  wire logic                  tx_start,
  input  wire logic [7:0]            tx_data,
  input  wire logic                  tx_bit9,
  output logic                       tx_line,
  output logic                       tx_busy,
  output logic                       tx_done,
  // Receive side
  input  wire logic                  rx_line,
  input  wire logic                  rx_allow,
  output logic                       rx_busy,
  output logic                       rx_done,
  output upoc_pkg::upoc_rxfrm_t      rx_frame
);

  // ****************************************
  // Transmit shifter
  // ****************************************
  // Frame length: mode 0 has 8 bits, mode 1 has 10, modes 2 and 3 have 11
  // One idle bit leads each frame so the start bit gets a whole bit period
  logic [11:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  logic [3:0]  tx_len;
  logic [3:0]  rx_len;
  logic        m0;
  logic        nine;
  assign m0     = (mode == upoc_pkg::UPOC_M0);
  assign nine   = mode[1];
  assign tx_len = m0 ? 4'h8 : (nine ? 4'hB : 4'hA);
  assign rx_len = tx_len;
  assign tx_busy = (tx_cnt_r != 4'h0);
  assign tx_line = tx_busy ? tx_sh_r[0] : 1'b1;

  // Ninth bit goes only into 11-bit frames; done pulses after the last data bit
  always_ff @(posedge aclk)
  begin
    tx_done <= 1'b0;
    if (!aresetn)
    begin
      tx_sh_r  <= 12'hFFF;
      tx_cnt_r <= 4'h0;
    end
    else if (tx_start && !tx_busy)
    begin
      tx_cnt_r <= tx_len + 4'h1;
      if (m0)
        tx_sh_r <= {3'b111, tx_data, 1'b1};
      else if (nine)
        tx_sh_r <= {1'b1, tx_bit9, tx_data, 1'b0, 1'b1};  // R7
      else
        tx_sh_r <= {2'b11, tx_data, 1'b0, 1'b1};
    end
    else if (bit_en && tx_busy)
    begin
      tx_sh_r  <= {1'b1, tx_sh_r[11:1]};
      tx_cnt_r <= tx_cnt_r - 4'h1;
      if (tx_cnt_r == (m0 ? 4'h1 : (nine ? 4'h2 : 4'h2)))
        tx_done <= 1'b1;  // R9
    end
  end

  // ****************************************
  // Receive shifter
  // ****************************************
  // Bits sampled once per bit enable; start seen as a low line outside mode 0
  logic [10:0] rx_sh_r;
  logic [3:0]  rx_cnt_r;
  assign rx_busy = (rx_cnt_r != 4'h0);

  always_ff @(posedge aclk)
  begin
    rx_done <= 1'b0;
    if (!aresetn)
    begin
      rx_sh_r  <= 11'h000;
      rx_cnt_r <= 4'h0;
      rx_frame <= '0;
    end
    else if (bit_en)
    begin
      if (!rx_busy && rx_allow && (m0 || !rx_line))
      begin
        // Mode 0 takes data bit 0 here, other modes the start bit
        rx_cnt_r <= rx_len - 4'h1;
        rx_sh_r  <= 11'h000;
        if (m0)
          rx_sh_r <= {rx_line, 10'h000};
      end
      else if (rx_busy)
      begin
        rx_sh_r  <= {rx_line, rx_sh_r[10:1]};
        rx_cnt_r <= rx_cnt_r - 4'h1;
        if (rx_cnt_r == 4'h1)
        begin
          rx_done <= 1'b1;  // R10
          if (m0)
            rx_frame <= '{data: {rx_line, rx_sh_r[10:4]}, bit9: 1'b0, stop: 1'b1};
          else if (nine)
            rx_frame <= '{data: rx_sh_r[9:2], bit9: rx_sh_r[10], stop: rx_line};
          else
            rx_frame <= '{data: rx_sh_r[10:3], bit9: rx_line, stop: rx_line};
        end
      end
    end
  end

endmodule

// [rtl/upoc_top.sv]
// Serial port one control block: control register, filtering, flags, AXI4-Lite slave.
// Assumes one 100 MHz clock, synchronous active-low reset, serial line synchronous.
//
// Notes on behaviour
// R1 - With alternate select clear, control bits 7 and 6 choose the port mode.
// R2 - With alternate select set, bit 7 is frame-error flag, set by hardware.
// R3 - Mode 1 with filter on accepts only stop one and matching address.
// R4 - Modes 2, 3 with filter on need ninth bit one and address match.
// R5 - Receive enable clear blocks reception; set enables it in modes 1 to 3.
// R6 - Mode 0 starts reception only with receive enable set and rx flag clear.
// R7 - Modes 2 and 3 transmit the ninth transmit bit as ninth data bit.
// R8 - Ninth received bit holds ninth bit, or stop bit in mode 1.
// R9 - Transmit-done flag set after last data bit, stays until software clears.
// R10 - Receive-done flag set after frame unless filtering rejects it.
// R11 - With interrupt enabled, either done flag raises the port interrupt.
// R12 - A sampled stop bit of zero is a frame error and sets the flag.
`timescale 1ns/1ps
module upoc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial line
  input  wire logic              rxd,
  output logic                   txd,
  // Interrupts
  output logic                   port_irq,
  output logic                   irq
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]  ctrl_r;
  logic        altsel_r;
  logic        ien_r;
  logic [7:0]  txbuf_r;
  logic [7:0]  rxbuf_r;
  logic [7:0]  given_r;
  logic [7:0]  bcast_r;
  logic [2:0]  irqst_r;
  logic [2:0]  irqmsk_r;
  logic [15:0] baud_r;
  logic [15:0] bdiv_r;
  logic        mode_bit_r;    // Stored mode bit 7 while the field shows the frame error
  logic        fe_r;
  logic        tx_go_r;

  // ****************************************
  // Bit-rate divider
  // ****************************************
  // One enable pulse per bit; the same pulse paces both directions
  logic bit_en;
  assign bit_en = (bdiv_r == 16'h0000);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bdiv_r <= upoc_pkg::BAUD_RST;
    else if (bit_en)
      bdiv_r <= baud_r;
    else
      bdiv_r <= bdiv_r - 16'h0001;
  end

  // ****************************************
  // Mode and receive gating
  // ****************************************
  upoc_pkg::upoc_mode_t mode;
  logic                 rx_allow;
  logic                 m0;
  // The frame-error view must not disturb the mode in use
  assign mode = upoc_pkg::upoc_mode_t'({mode_bit_r, ctrl_r[upoc_pkg::MODE_LO_BIT]});  // R1
  assign m0   = (mode == upoc_pkg::UPOC_M0);
  assign rx_allow = ctrl_r[upoc_pkg::RXEN_BIT]                           // R5
                  && (!m0 || !ctrl_r[upoc_pkg::RXDONE_BIT]);             // R6

  // ****************************************
  // Shifter
  // ****************************************
  logic                  tx_busy;
  logic                  tx_done;
  logic                  rx_busy;
  logic                  rx_done;
  upoc_pkg::upoc_rxfrm_t rx_frame;

  upoc_shift u_shift (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .bit_en   (bit_en),
    .mode     (mode),
    .tx_start (tx_go_r),
    .tx_data  (txbuf_r),
    .tx_bit9  (ctrl_r[upoc_pkg::TX9_BIT]),
    .tx_line  (txd),
    .tx_busy  (tx_busy),
    .tx_done  (tx_done),
    .rx_line  (rxd),
    .rx_allow (rx_allow),
    .rx_busy  (rx_busy),
    .rx_done  (rx_done),
    .rx_frame (rx_frame)
  );

  // ****************************************
  // Reception acceptance
  // ****************************************
  logic addr_hit;
  logic rx_accept;
  logic frame_err;
  assign addr_hit  = (rx_frame.data == given_r) || (rx_frame.data == bcast_r);
  // Filter gates on stop bit in mode 1, ninth bit in modes 2 and 3, nothing in mode 0
  assign rx_accept = m0 || !ctrl_r[upoc_pkg::MPF_BIT]                     // R3 R4
                   || (rx_frame.bit9 && addr_hit);                        // R3 R4
  assign frame_err = rx_done && !m0 && !rx_frame.stop;                    // R12

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Address and data are caught in either order; response after both
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_have_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_have_r;
  logic              wr_fire;
  logic              wr_lane0;
  logic [7:0]        wbyte;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb_r[0];
  assign wbyte         = w_data_r[7:0];

  // Decoded write strobes
  logic wr_ctrl;
  logic wr_aux;
  logic wr_tx;
  logic wr_addr;
  logic wr_irqst;
  logic wr_irqmsk;
  logic wr_baud;
  logic wr_known;
  assign wr_ctrl   = wr_lane0 && (aw_addr_r[7:0] == upoc_pkg::CTRL_OFS);
  assign wr_aux    = wr_lane0 && (aw_addr_r[7:0] == upoc_pkg::AUX_OFS);
  assign wr_tx     = wr_lane0 && (aw_addr_r[7:0] == upoc_pkg::TXDATA_OFS);
  assign wr_addr   = wr_fire && (aw_addr_r[7:0] == upoc_pkg::ADDR_OFS);
  assign wr_irqst  = wr_lane0 && (aw_addr_r[7:0] == upoc_pkg::IRQST_OFS);
  assign wr_irqmsk = wr_lane0 && (aw_addr_r[7:0] == upoc_pkg::IRQMSK_OFS);
  assign wr_baud   = wr_fire && (aw_addr_r[7:0] == upoc_pkg::BAUD_OFS);
  assign wr_known  = (aw_addr_r[7:0] == upoc_pkg::CTRL_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::AUX_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::TXDATA_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::RXDATA_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::ADDR_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::IRQST_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::IRQMSK_OFS)
                   || (aw_addr_r[7:0] == upoc_pkg::BAUD_OFS);

  // Channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= upoc_pkg::RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? upoc_pkg::RESP_OK : upoc_pkg::RESP_ERR;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control register and flags
  // ****************************************
  // Hardware sets win over a software clear in the same cycle
  logic [7:0] ctrl_nxt;
  logic       fe_nxt;
  always_comb
  begin
    ctrl_nxt = wr_ctrl ? wbyte : ctrl_r;
    if (tx_done)
      ctrl_nxt[upoc_pkg::TXDONE_BIT] = 1'b1;                             // R9
    if (rx_done && rx_accept)
    begin
      ctrl_nxt[upoc_pkg::RXDONE_BIT] = 1'b1;                             // R10
      if (!m0)
        ctrl_nxt[upoc_pkg::RX9_BIT] = rx_frame.bit9;                     // R8
    end
    fe_nxt = (wr_ctrl && altsel_r) ? wbyte[upoc_pkg::MODE_HI_BIT] : fe_r;
    if (frame_err)
      fe_nxt = 1'b1;                                                     // R12
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r     <= upoc_pkg::CTRL_RST;
      mode_bit_r <= 1'b0;
      fe_r       <= 1'b0;
      altsel_r   <= 1'b0;
      ien_r      <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      fe_r   <= fe_nxt;                                                  // R2
      if (wr_ctrl && !altsel_r)
        mode_bit_r <= wbyte[upoc_pkg::MODE_HI_BIT];                      // R1
      if (wr_aux)
      begin
        altsel_r <= wbyte[upoc_pkg::ALTSEL_BIT];
        ien_r    <= wbyte[upoc_pkg::IEN_BIT];
      end
    end
  end

  // ****************************************
  // Data, address, event registers
  // ****************************************
  logic [2:0] ev_set;
  assign ev_set = {frame_err, rx_done && rx_accept, tx_done};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txbuf_r  <= 8'h00;
      rxbuf_r  <= 8'h00;
      given_r  <= upoc_pkg::GIVEN_RST;
      bcast_r  <= upoc_pkg::BCAST_RST;
      irqst_r  <= 3'h0;
      irqmsk_r <= 3'h0;
      baud_r   <= upoc_pkg::BAUD_RST;
      tx_go_r  <= 1'b0;
    end
    else
    begin
      tx_go_r <= wr_tx;  // Write while busy is dropped by the shifter
      if (wr_tx)
        txbuf_r <= wbyte;
      if (rx_done && rx_accept)
        rxbuf_r <= rx_frame.data;
      if (wr_addr && w_strb_r[0])
        given_r <= w_data_r[7:0];
      if (wr_addr && w_strb_r[1])
        bcast_r <= w_data_r[15:8];
      irqst_r <= (irqst_r & ~(wr_irqst ? wbyte[2:0] : 3'h0)) | ev_set;
      if (wr_irqmsk)
        irqmsk_r <= wbyte[2:0];
      if (wr_baud && w_strb_r[0])
        baud_r[7:0] <= w_data_r[7:0];
      if (wr_baud && w_strb_r[1])
        baud_r[15:8] <= w_data_r[15:8];
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  assign port_irq = ien_r && (ctrl_r[upoc_pkg::TXDONE_BIT]               // R11
                  || ctrl_r[upoc_pkg::RXDONE_BIT]);                      // R11
  assign irq      = |(irqst_r & irqmsk_r);

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // Bit 7 shows either the mode bit or the frame-error flag
  logic [7:0]  ctrl_view;
  logic [31:0] rd_word;
  logic        rd_known;
  logic [7:0]  ra;
  assign ra        = s_axi_araddr[7:0];
  assign ctrl_view = {altsel_r ? fe_r : mode_bit_r, ctrl_r[6:0]};        // R2
  assign rd_known  = (ra == upoc_pkg::CTRL_OFS) || (ra == upoc_pkg::AUX_OFS)
                   || (ra == upoc_pkg::TXDATA_OFS) || (ra == upoc_pkg::RXDATA_OFS)
                   || (ra == upoc_pkg::ADDR_OFS) || (ra == upoc_pkg::IRQST_OFS)
                   || (ra == upoc_pkg::IRQMSK_OFS) || (ra == upoc_pkg::BAUD_OFS);
  assign rd_word =
      (ra == upoc_pkg::CTRL_OFS)   ? {24'h000000, ctrl_view} :
      (ra == upoc_pkg::AUX_OFS)    ? {26'h0, rx_busy, tx_busy, 2'b00, ien_r, altsel_r} :
      (ra == upoc_pkg::TXDATA_OFS) ? {24'h000000, txbuf_r} :
      (ra == upoc_pkg::RXDATA_OFS) ? {24'h000000, rxbuf_r} :
      (ra == upoc_pkg::ADDR_OFS)   ? {16'h0000, bcast_r, given_r} :
      (ra == upoc_pkg::IRQST_OFS)  ? {29'h0, irqst_r} :
      (ra == upoc_pkg::IRQMSK_OFS) ? {29'h0, irqmsk_r} :
      (ra == upoc_pkg::BAUD_OFS)   ? {16'h0000, baud_r} : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= upoc_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? upoc_pkg::RESP_OK : upoc_pkg::RESP_ERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_tx_done_sets: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    tx_done |=> ctrl_r[upoc_pkg::TXDONE_BIT])
    else $error("transmit done flag not set");
  a_rx_reject_holds: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (rx_done && !rx_accept && !ctrl_r[upoc_pkg::RXDONE_BIT] && !wr_ctrl)
      |=> !ctrl_r[upoc_pkg::RXDONE_BIT])
    else $error("rejected frame set receive flag");
  a_rx_done_sets: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (rx_done && rx_accept) |=> ctrl_r[upoc_pkg::RXDONE_BIT])
    else $error("receive done flag not set");
  a_ninth_capture: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (rx_done && rx_accept && !m0) |=> ctrl_r[upoc_pkg::RX9_BIT] == $past(rx_frame.bit9))
    else $error("ninth received bit wrong");
  a_fe_sets: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    frame_err |=> fe_r)
    else $error("frame error not flagged");
  a_fe_view: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (s_axi_arvalid && s_axi_arready && (ra == upoc_pkg::CTRL_OFS) && altsel_r)
      |=> s_axi_rdata[7] == $past(fe_r))
    else $error("bit seven not frame error");
  a_m0_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (m0 && ctrl_r[upoc_pkg::RXDONE_BIT]) |-> !rx_allow)
    else $error("mode 0 reception not gated");
  a_rxen_off: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (!ctrl_r[upoc_pkg::RXEN_BIT] && !rx_busy) |=> !rx_busy)
    else $error("reception started while disabled");
  a_port_irq: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (ien_r && !wr_aux && (tx_done || (rx_done && rx_accept))) |=> port_irq)
    else $error("port interrupt missing");

endmodule

// [test/upoc_node.sv]
// Far-side serial node: sends frames on rxd and captures frames from txd.
// Assumes BP clock cycles per bit and a line that idles high.
`timescale 1ns/1ps
module upoc_node #(
  parameter int BP = 4
) (
  // Clock
  input  wire logic aclk,
  // Serial line
  input  wire logic txd,
  output logic      rxd
);
  logic [8:0] got_q[$];
  int         nb = 8;

  // Start, data LSB first, optional ninth bit, stop; idle high afterwards
  task automatic send(input logic [7:0] d, input logic w9, input logic b9);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};  // In a 10-bit frame b9 is the stop bit
    for (int i = 0; i < (w9 ? 11 : 10); i++)
    begin
      rxd <= f[i];
      repeat (BP) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask

  // Mid-bit capture of nb bits after each start edge
  initial
  begin
    logic [8:0] v;
    rxd = 1'b1;
    forever
    begin
      @(negedge txd);
      repeat (BP / 2) @(posedge aclk);
      v = '0;
      for (int i = 0; i < nb; i++)
      begin
        repeat (BP) @(posedge aclk);
        v[i] = txd;
      end
      got_q.push_back(v);
      repeat (BP) @(posedge aclk);
    end
  end
endmodule

// [test/upoc_top_bench.sv]
// Self-checking bench: AXI4-Lite master, expectation model, serial partner node.
// Assumes upoc_top with 8-bit addresses and the bit period shortened to 4 cycles.
`timescale 1ns/1ps
module upoc_top_bench;
  localparam int         BP    = 4;
  localparam logic [7:0] GIVEN = 8'h5A;
  localparam logic [7:0] CC [8] = '{8'h50, 8'h70, 8'h70, 8'h70, 8'hF0, 8'hF0, 8'h90, 8'h80};
  localparam logic [7:0] B9    = 8'hA6;
  localparam int         DK [8] = '{0, 1, 2, 1, 3, 3, 0, 0};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxd, txd, port_irq, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r, b_r;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  integer      seed = 32'h9283319f;

  upoc_top i_upoc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd(rxd), .txd(txd), .port_irq(port_irq), .irq(irq));
  upoc_node #(.BP(BP)) i_upoc_node (.aclk(aclk), .txd(txd), .rxd(rxd));

  // Clock, and a cycle ceiling that cuts a hang short
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Write: one edge of gap first, so bready never toggles twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    hb = 1'b0;
    while (!hb)
    begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      b_r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    hr = 1'b0;
    while (!hr)
    begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      rd_v = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence: reset, map checks, filtered receptions, frame error, transmit
  initial
  begin
    logic [7:0] d;
    logic       b9, ex;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(upoc_pkg::CTRL_OFS);
    chk(rd_v, 32'h0, "ctrl reset");
    rd(8'h20);
    chk({30'h0, rd_r}, 32'h2, "unmapped resp");
    wr(8'h24, 32'h1);
    chk({30'h0, b_r}, 32'h2, "unmapped wr resp");
    wr(upoc_pkg::BAUD_OFS, BP - 1);
    chk({30'h0, b_r}, 32'h0, "baud wr resp");
    // The divider finishes its reset count before the short period applies
    repeat (upoc_pkg::BAUD_RST + 16'h0004) @(posedge aclk);
    wr(upoc_pkg::ADDR_OFS, {16'h0, 8'hFF, GIVEN});
    for (int i = 0; i < 8; i++)
    begin
      b9 = B9[i];
      d = $random(seed);
      if (DK[i] == 1) d = GIVEN;
      if (DK[i] == 2) d = {1'b0, d[6:1], 1'b1};
      if (DK[i] == 3) d = 8'hFF;
      wr(upoc_pkg::CTRL_OFS, CC[i]);
      i_upoc_node.send(d, CC[i][7], b9);
      repeat (8) @(posedge aclk);
      ex = CC[i][4] && (!CC[i][5] || (b9 && (d == GIVEN || d == 8'hFF)));
      rd(upoc_pkg::CTRL_OFS);
      chk(rd_v & {29'h1FFFFFFF, ex, 2'b11}, {24'h0, CC[i] | {5'h0, ex & b9, 1'b0, ex}}, "rx");
      rd(upoc_pkg::RXDATA_OFS);
      if (ex) chk(rd_v, {24'h0, d}, "rx data");
    end
    wr(upoc_pkg::IRQST_OFS, 32'h7);
    wr(upoc_pkg::CTRL_OFS, 32'h50);
    wr(upoc_pkg::AUX_OFS, 32'h1);
    i_upoc_node.send(8'h3C, 1'b0, 1'b0);
    repeat (8) @(posedge aclk);
    rd(upoc_pkg::CTRL_OFS);
    chk(rd_v, 32'hD1, "frame error");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(upoc_pkg::IRQMSK_OFS, 32'h4);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(upoc_pkg::IRQST_OFS, 32'h4);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(upoc_pkg::CTRL_OFS, 32'h50);
    rd(upoc_pkg::CTRL_OFS);
    chk(rd_v, 32'h50, "fe clear");
    // Alternate select off first, so bit 7 lands in the mode
    wr(upoc_pkg::AUX_OFS, 32'h2);
    wr(upoc_pkg::CTRL_OFS, 32'h88);
    i_upoc_node.nb = 9;
    d = $random(seed);
    wr(upoc_pkg::TXDATA_OFS, {24'h0, d});
    repeat (60) @(posedge aclk);
    chk({23'h0, i_upoc_node.got_q.pop_front()}, {23'h0, 1'b1, d}, "tx frame");
    rd(upoc_pkg::CTRL_OFS);
    chk(rd_v, 32'h8A, "tx done");
    @(negedge aclk);
    chk({31'h0, port_irq}, 32'h1, "port irq");
    wr(upoc_pkg::CTRL_OFS, 32'h88);
    @(negedge aclk);
    chk({31'h0, port_irq}, 32'h0, "port irq off");
    // Mode 0 reads eight bits of the idle line, then stays gated by its flag
    wr(upoc_pkg::CTRL_OFS, 32'h10);
    repeat (48) @(posedge aclk);
    rd(upoc_pkg::CTRL_OFS);
    chk(rd_v, 32'h11, "mode 0 rx");
    rd(upoc_pkg::RXDATA_OFS);
    chk(rd_v, 32'hFF, "mode 0 data");
    end_of_test();
  end
endmodule
